// File: pse_limit_and_event_regs.sv
/*
  Register, event and current limit logic for a four-port PSE, reached
  over an I2C target with split data in and data out pins.
  Assumes SCL and SDI are synchronous to clk_in and that the analog
  front end reports signature, class, removal and port current.
*/
// Contract
// [R1] A port's main power turns on only after detection and classification both succeed.
// [R2] Each port's current is clamped at the ceiling decoded from its ceiling code.
// [R3] The ceiling code is decoded from a fixed list of codes into milliamps.
// [R4] Overcurrent above the cutoff is tolerated briefly, but sustained excess shuts the port.
// [R5] The cutoff field is 6 bits with an 18.75 mA step in normal range.
// [R6] With the double bit at 0 the cutoff step is 37.5 mA.
// [R7] In host mode the host should program class-matched ceiling and cutoff values.
// [R8] The host selects host mode when link-layer power negotiation is needed.
// [R9] In autonomous mode a Class 4 port gets the Type 2 ceiling and cutoff by itself.
// [R10] Clear-on-read registers return their value, clear on the read, ignore writes.
// [R11] Read/write registers store writes and read back without side effects.
// [R12] Read-only registers are unchanged by reads and ignore writes.
// [R13] Set-only registers act on writes and read back undefined data.
// [R14] A low mode pin at power-up puts the device in host mode.
// [R15] The target address is 010 followed by the four address straps.
// [R16] The interrupt output changes only between I2C transactions.
// [R17] Event register pairs share flags, so a clearing read clears both copies.
module pse_limit_and_event_regs
  import pse_regs_pkg::*;
#(
  parameter int PORTS = 4,
  parameter int CUT_CYC = CUT_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Straps and supply
  input wire logic mode_in,
  input wire logic [3:0] addr_strap_in,
  input wire logic supply_alarm_in,
  // I2C pins
  input wire logic scl_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic irq_b_out,
  // Front end events per port
  input wire logic [PORTS-1:0] sig_ok_in,
  input wire logic [PORTS-1:0] class_done_in,
  input wire logic [3*PORTS-1:0] class_code_in,
  input wire logic [PORTS-1:0] pd_removed_in,
  input wire logic [12*PORTS-1:0] port_ma_in,
  // Port power controls
  output logic [PORTS-1:0] power_on_out,
  output logic [12*PORTS-1:0] ceiling_ma_out,
  output logic [14*PORTS-1:0] cutoff_q_out
);

  // Elaboration checks: the event bytes pack exactly four ports
  if (PORTS != 4) begin : g_bad_ports
    $error("Event registers hold exactly four ports");
  end
  if (CUT_CYC < 1) begin : g_bad_cut
    $error("Cutoff time must be at least one cycle");
  end

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_ACK_A = 7'b0000100,
    ST_PTR = 7'b0001000,
    ST_ACK_W = 7'b0010000,
    ST_RD = 7'b0100000,
    ST_MACK = 7'b1000000
  } i2c_state_type;

  i2c_state_type state;
  logic scl_q, sdi_q, bus_active, rw, mack_ok, sdo_low, hw_mode, mode_seen, supply, ptr_valid;
  logic [3:0] cnt;
  logic [7:0] shreg, ptr, tx, irq_mask;
  logic [7:0] power_ev, sense_ev, fault_ev;
  logic [7:0] ceil_code [PORTS];
  logic [7:0] cut_code [PORTS];
  logic [PORTS-1:0] sig_seen, classed, pwr, pgd_set, psc_set, sig_set, cls_set;
  logic [PORTS-1:0] dis_set, cut_set;

  // Bus edge detection on the registered pin samples
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_c = scl_in & scl_q & sdi_q & ~sdi_in;
  wire stop_c = scl_in & scl_q & ~sdi_q & sdi_in;
  wire addr_hit = (shreg[7:1] == {I2C_ADDR_HI, addr_strap_in}); // [R15]
  wire byte_done = (cnt == 4'h8);
  wire wr_stb = scl_fall & byte_done & (state == ST_PTR) & ptr_valid;
  wire rd_load = scl_fall & ((state == ST_ACK_A & rw) | (state == ST_MACK & mack_ok));

  // Interrupt cause is a view of the event groups plus the supply flag
  wire [7:0] irq_cause = {supply, 1'b0, |fault_ev[3:0], |sense_ev[7:4],
                          |sense_ev[3:0], |fault_ev[7:4], |power_ev[7:4], |power_ev[3:0]};

  // Read data mux; unmapped and set-only reads give zero
  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h00;
    unique case (ptr)
      ADDR_IRQ_CAUSE: rd_data = irq_cause; // [R12]
      ADDR_IRQ_MASK: rd_data = irq_mask; // [R11]
      ADDR_POWER_EV, ADDR_POWER_EV_CLR: rd_data = power_ev; // [R17]
      ADDR_SENSE_EV, ADDR_SENSE_EV_CLR: rd_data = sense_ev; // [R17]
      ADDR_FAULT_EV, ADDR_FAULT_EV_CLR: rd_data = fault_ev; // [R17]
      default: begin // No set-only byte in this range; unmapped reads give zero [R13]
        if (ptr[7:2] == ADDR_CEIL_BASE[7:2]) rd_data = ceil_code[ptr[1:0]];
        else if (ptr[7:2] == ADDR_CUT_BASE[7:2]) rd_data = cut_code[ptr[1:0]];
      end
    endcase
  end

  // Clearing reads on the odd event offsets
  wire clr_power = rd_load & (ptr == ADDR_POWER_EV_CLR); // [R10]
  wire clr_sense = rd_load & (ptr == ADDR_SENSE_EV_CLR); // [R10]
  wire clr_fault = rd_load & (ptr == ADDR_FAULT_EV_CLR); // [R10]
  wire wr_mask = wr_stb & (ptr == ADDR_IRQ_MASK); // [R11]
  wire wr_ceil = wr_stb & (ptr[7:2] == ADDR_CEIL_BASE[7:2]);
  wire wr_cut = wr_stb & (ptr[7:2] == ADDR_CUT_BASE[7:2]);

  // Pin sampling for edge detection
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_q <= 1'b1;
      sdi_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sdi_q <= sdi_in;
    end
  end

  // Mode strap caught once after reset release, not under reset
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_seen <= 1'b0;
      hw_mode <= 1'b0;
    end else if (!mode_seen) begin
      mode_seen <= 1'b1;
      hw_mode <= mode_in; // [R14]
    end
  end

  // I2C target: address, pointer, write bytes, read bytes with auto increment
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      ptr_valid <= 1'b0;
      tx <= 8'h00;
      rw <= 1'b0;
      mack_ok <= 1'b0;
      sdo_low <= 1'b0;
    end else if (start_c) begin
      state <= ST_ADDR;
      cnt <= 4'h0;
      sdo_low <= 1'b0;
    end else if (stop_c) begin
      state <= ST_IDLE;
      sdo_low <= 1'b0;
    end else if (scl_rise) begin
      if (state == ST_ADDR || state == ST_PTR) begin
        shreg <= {shreg[6:0], sdi_in};
        cnt <= cnt + 4'h1;
      end else if (state == ST_RD) begin
        cnt <= cnt + 4'h1;
      end else if (state == ST_MACK) begin
        mack_ok <= ~sdi_in;
      end
    end else if (scl_fall) begin
      unique case (state)
        ST_ADDR: if (byte_done) begin
          cnt <= 4'h0;
          rw <= shreg[0];
          ptr_valid <= 1'b0;
          sdo_low <= addr_hit;
          state <= addr_hit ? ST_ACK_A : ST_IDLE;
        end
        ST_ACK_A: begin
          cnt <= 4'h0;
          if (rw) begin
            tx <= rd_data;
            sdo_low <= ~rd_data[7];
            ptr <= ptr + 8'h01;
            state <= ST_RD;
          end else begin
            sdo_low <= 1'b0;
            state <= ST_PTR;
          end
        end
        ST_PTR: if (byte_done) begin
          cnt <= 4'h0;
          sdo_low <= 1'b1;
          state <= ST_ACK_W;
          if (!ptr_valid) ptr <= shreg;
          else ptr <= ptr + 8'h01;
          ptr_valid <= 1'b1;
        end
        ST_ACK_W: begin
          sdo_low <= 1'b0;
          state <= ST_PTR;
        end
        ST_RD: begin
          if (byte_done) begin
            sdo_low <= 1'b0;
            state <= ST_MACK;
          end else begin
            tx <= {tx[6:0], 1'b0};
            sdo_low <= ~tx[6];
          end
        end
        ST_MACK: begin
          cnt <= 4'h0;
          if (mack_ok) begin
            tx <= rd_data;
            sdo_low <= ~rd_data[7];
            ptr <= ptr + 8'h01;
            state <= ST_RD;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign sdo_out = ~sdo_low;

  // Interrupt pin frozen while a transaction is open
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_active <= 1'b0;
      irq_b_out <= 1'b0;
    end else begin
      if (start_c) bus_active <= 1'b1;
      else if (stop_c) bus_active <= 1'b0;
      if (!bus_active && !start_c) irq_b_out <= ~|(irq_cause & irq_mask); // [R16]
    end
  end

  // Mask and supply flag
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_mask <= RST_IRQ_MASK;
      supply <= RST_IRQ_CAUSE[IRQ_SUPPLY];
    end else begin
      if (wr_mask) irq_mask <= shreg; // [R11]
      supply <= supply_alarm_in;
    end
  end

  // Event flags: a new event wins over a clearing read in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      power_ev <= RST_EVENTS;
      sense_ev <= RST_EVENTS;
      fault_ev <= RST_EVENTS;
    end else begin
      power_ev <= (clr_power ? 8'h00 : power_ev) | {pgd_set, psc_set}; // [R10]
      sense_ev <= (clr_sense ? 8'h00 : sense_ev) | {cls_set, sig_set}; // [R10]
      fault_ev <= (clr_fault ? 8'h00 : fault_ev) | {dis_set, cut_set}; // [R10]
    end
  end

  // Ceiling code to milliamps
  function automatic logic [11:0] ceil_decode(input logic [7:0] code);
    unique case (code)
      8'h88: ceil_decode = 12'd106; // [R3]
      8'h08: ceil_decode = 12'd213;
      8'h89: ceil_decode = 12'd359;
      8'h80: ceil_decode = 12'd425;
      8'h8a: ceil_decode = 12'd531;
      8'h90: ceil_decode = 12'd638;
      8'h9a: ceil_decode = 12'd744;
      8'hc0: ceil_decode = 12'd850;
      8'hca: ceil_decode = 12'd956;
      8'hd0: ceil_decode = 12'd1063;
      8'hda: ceil_decode = 12'd1169;
      8'hd1: ceil_decode = 12'd1275;
      8'hdb: ceil_decode = 12'd1381;
      8'h49: ceil_decode = 12'd1488;
      8'h40: ceil_decode = 12'd1700;
      default: ceil_decode = 12'd425; // Unlisted codes fall back to the Type 1 ceiling
    endcase
  endfunction : ceil_decode

  // Per-port sequencing, limits and cutoff timing
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    logic [31:0] over_cnt;
    wire [2:0] cls = class_code_in[3*p +: 3];
    wire [11:0] cur_ma = port_ma_in[12*p +: 12];
    wire [7:0] step_q = cut_code[p][CUT_DOUBLE_BIT] ? CUT_STEP_NORMAL_Q : CUT_STEP_DOUBLE_Q; // [R6]
    wire [13:0] cut_q = {8'h00, cut_code[p][CUT_FIELD_W-1:0]} * {6'h00, step_q}; // [R5]
    wire over = pwr[p] & ({cur_ma, 2'b00} > cut_q);
    wire cls_ok = class_done_in[p] & sig_seen[p] & (cls != CLASS_OVER);
    wire cut_trip = over & (over_cnt == 32'(CUT_CYC - 1));
    logic [7:0] hw_cut;
    always_comb begin
      unique case (cls)
        CLASS_1: hw_cut = CUT_CLASS1;
        CLASS_2: hw_cut = CUT_CLASS2;
        CLASS_4: hw_cut = CUT_CLASS4;
        default: hw_cut = CUT_CLASS3;
      endcase
    end
    assign sig_set[p] = sig_ok_in[p];
    assign cls_set[p] = cls_ok;
    assign pgd_set[p] = classed[p] & ~pwr[p];
    assign cut_set[p] = cut_trip;
    assign dis_set[p] = pd_removed_in[p] & pwr[p];
    assign psc_set[p] = pgd_set[p] | cut_trip | dis_set[p];

    // Power state; turns on two cycles after class_done_in, the cycle after classed is set
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        sig_seen[p] <= 1'b0;
        classed[p] <= 1'b0;
        pwr[p] <= 1'b0;
        over_cnt <= 32'h0;
      end else begin
        if (cut_trip || dis_set[p]) begin
          pwr[p] <= 1'b0; // [R4]
          sig_seen[p] <= 1'b0;
          classed[p] <= 1'b0;
        end else if (pgd_set[p]) begin
          pwr[p] <= 1'b1; // [R1]
          classed[p] <= 1'b0;
        end else begin
          if (sig_ok_in[p]) sig_seen[p] <= 1'b1;
          if (cls_ok) classed[p] <= 1'b1; // [R1]
        end
        // Brief excursions reset the timer; only a sustained run trips
        over_cnt <= over ? over_cnt + 32'h1 : 32'h0; // [R4]
      end
    end

    // Limit codes: host writes in host mode, class defaults in autonomous mode
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        ceil_code[p] <= CEIL_TYPE1;
        cut_code[p] <= CUT_CLASS3;
      end else if (hw_mode && cls_ok) begin
        ceil_code[p] <= (cls == CLASS_4) ? CEIL_TYPE2 : CEIL_TYPE1; // [R9]
        cut_code[p] <= hw_cut; // [R9]
      end else begin
        if (wr_ceil && ptr[1:0] == 2'(p)) ceil_code[p] <= shreg;
        if (wr_cut && ptr[1:0] == 2'(p)) cut_code[p] <= shreg;
      end
    end

    // Registered limit outputs to the current regulator
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        ceiling_ma_out[12*p +: 12] <= 12'h000;
        cutoff_q_out[14*p +: 14] <= 14'h0000;
      end else begin
        ceiling_ma_out[12*p +: 12] <= ceil_decode(ceil_code[p]); // [R2]
        cutoff_q_out[14*p +: 14] <= cut_q;
      end
    end
  end

  assign power_on_out = pwr;

endmodule : pse_limit_and_event_regs

// File: pse_regs_pkg.sv
/*
  Shared constants for the four-port PSE limit and event register block:
  register offsets, reset values, current codes, class defaults and timings.
  Assumes a byte-wide register space addressed by an 8-bit pointer.
*/
package pse_regs_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_IRQ_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h01;
  localparam logic [7:0] ADDR_POWER_EV = 8'h02;
  localparam logic [7:0] ADDR_POWER_EV_CLR = 8'h03;
  localparam logic [7:0] ADDR_SENSE_EV = 8'h04;
  localparam logic [7:0] ADDR_SENSE_EV_CLR = 8'h05;
  localparam logic [7:0] ADDR_FAULT_EV = 8'h06;
  localparam logic [7:0] ADDR_FAULT_EV_CLR = 8'h07;
  localparam logic [7:0] ADDR_CEIL_BASE = 8'h20; // Four ceiling codes, 20h..23h
  localparam logic [7:0] ADDR_CUT_BASE = 8'h24; // Four cutoff fields, 24h..27h
  // Reset values
  localparam logic [7:0] RST_IRQ_CAUSE = 8'h80;
  localparam logic [7:0] RST_IRQ_MASK = 8'h80;
  localparam logic [7:0] RST_EVENTS = 8'h00;
  // Interrupt cause bit positions
  localparam int IRQ_SUPPLY = 7;
  localparam int IRQ_START = 6;
  localparam int IRQ_CUT = 5;
  localparam int IRQ_CLASS = 4;
  localparam int IRQ_DET = 3;
  localparam int IRQ_DIS = 2;
  localparam int IRQ_PGD = 1;
  localparam int IRQ_PER = 0;
  // Cutoff field layout
  localparam int CUT_DOUBLE_BIT = 6;
  localparam int CUT_FIELD_W = 6;
  // Cutoff step sizes in quarter milliamps (18.75 mA and 37.5 mA)
  localparam logic [7:0] CUT_STEP_NORMAL_Q = 8'h4b;
  localparam logic [7:0] CUT_STEP_DOUBLE_Q = 8'h96;
  // Autonomous class defaults: ceiling and cutoff codes
  localparam logic [7:0] CEIL_TYPE1 = 8'h80;
  localparam logic [7:0] CEIL_TYPE2 = 8'hc0;
  localparam logic [7:0] CUT_CLASS1 = 8'hc6;
  localparam logic [7:0] CUT_CLASS2 = 8'hcb;
  localparam logic [7:0] CUT_CLASS3 = 8'hd4;
  localparam logic [7:0] CUT_CLASS4 = 8'he2;
  // Class result codes
  localparam logic [2:0] CLASS_1 = 3'h1;
  localparam logic [2:0] CLASS_2 = 3'h2;
  localparam logic [2:0] CLASS_4 = 3'h4;
  localparam logic [2:0] CLASS_OVER = 3'h7;
  // Target address upper bits
  localparam logic [2:0] I2C_ADDR_HI = 3'h2;
  // Cutoff overload time and clock rate
  localparam int CUT_TIME_MS = 50;
  localparam int CLK_MHZ = 250;
  localparam int CUT_CYCLES = CUT_TIME_MS * CLK_MHZ * 1000;
endpackage : pse_regs_pkg

// File: pse_i2c_host.sv
/*
  I2C controller model for the PSE register block, on split data pins.
  Assumes the target samples SCL and SDA on clk_in and answers in a cycle.
*/
module pse_i2c_host (
  // Clock
  input wire logic clk_in,
  // Bus pins
  input wire logic sdo_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv = 1'b1;
  logic scl = 1'b1;
  logic acked;
  int half = 4;
  // Open-drain wire with pull-up: low if either side pulls
  assign sda_out = drv & sdo_in;
  assign scl_out = scl;
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    drv = 1'b1;
    tick(half);
    scl = 1'b1;
    tick(half);
    drv = 1'b0;
    tick(half);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    drv = 1'b0;
    tick(half);
    scl = 1'b1;
    tick(half);
    drv = 1'b1;
    tick(half);
  endtask : stop
  // Data set while clock is low, sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    drv = b;
    tick(half);
    scl = 1'b1;
    tick(half);
    r = sda_out;
    scl = 1'b0;
  endtask : bit_io
  task automatic put_byte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    acked = acked & ~r;
  endtask : put_byte
  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(nack, r);
  endtask : get_byte
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, d);
    acked = 1'b1;
    start();
    put_byte({a, 1'b0});
    put_byte(p);
    put_byte(d);
    stop();
  endtask : write_reg
  // Pointer write, repeated start, one byte read ended by no-ack
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
    acked = 1'b1;
    start();
    put_byte({a, 1'b0});
    put_byte(p);
    start();
    put_byte({a, 1'b1});
    get_byte(1'b1, d);
    stop();
  endtask : read_reg
endmodule : pse_i2c_host

// File: pse_limit_and_event_regs_sva.sv
/*
  Checker for the PSE register block: port 0 power and the I2C pins.
  Assumes one clock domain and an active-low asynchronous reset.
*/
module pse_limit_and_event_regs_sva
  import pse_regs_pkg::*;
#(
  parameter int PORTS = 4,
  parameter int CUT_CYC = CUT_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Pins
  input wire logic mode_in,
  input wire logic scl_in,
  input wire logic sdi_in,
  input wire logic sdo_out,
  input wire logic irq_b_out,
  // Port events and controls
  input wire logic [PORTS-1:0] class_done_in,
  input wire logic [3*PORTS-1:0] class_code_in,
  input wire logic [PORTS-1:0] pd_removed_in,
  input wire logic [12*PORTS-1:0] port_ma_in,
  input wire logic [PORTS-1:0] power_on_out,
  input wire logic [12*PORTS-1:0] ceiling_ma_out,
  input wire logic [14*PORTS-1:0] cutoff_q_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic scl_q;
  logic sdi_q;
  logic busy;
  int over_cnt;
  wire over = power_on_out[0] && ({port_ma_in[11:0], 2'b00} > cutoff_q_out[13:0]);
  // Open transaction and length of the present overload
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_q <= 1'b1;
      sdi_q <= 1'b1;
      busy <= 1'b0;
      over_cnt <= 0;
    end else begin
      scl_q <= scl_in;
      sdi_q <= sdi_in;
      if (scl_q && scl_in && sdi_q != sdi_in) busy <= !sdi_in;
      over_cnt <= over ? over_cnt + 1 : 0;
    end
  end
  a_power_after_class: assert property ($rose(power_on_out[0]) |->
    $past(class_done_in[0], 2) && $past(class_code_in[2:0], 2) != CLASS_OVER)
    else $error("power rose without class result");
  a_over_refused: assert property (class_done_in[0] && class_code_in[2:0] == CLASS_OVER
    && !power_on_out[0] |=> !power_on_out[0]) else $error("overcurrent class powered");
  a_removal_off: assert property (pd_removed_in[0] |=> !power_on_out[0])
    else $error("power stayed after removal");
  a_cut_bound: assert property (over_cnt <= CUT_CYC + 2)
    else $error("overload not shut down");
  a_cut_tolerant: assert property ($fell(power_on_out[0]) && !$past(pd_removed_in[0]) |->
    $past(over_cnt) >= CUT_CYC - 2) else $error("port shut on transient");
  a_auto_class4: assert property (mode_in && class_done_in[0] && class_code_in[2:0] == CLASS_4
    |-> ##[1:3] ceiling_ma_out[11:0] == 12'h352 && cutoff_q_out[13:0] == 14'h09f6)
    else $error("class 4 defaults not applied");
  a_irq_quiet: assert property ($changed(irq_b_out) |-> !$past(busy))
    else $error("interrupt changed in transaction");
  a_sdo_released: assert property (!busy && !$past(busy) |-> sdo_out)
    else $error("data pulled low while idle");
endmodule : pse_limit_and_event_regs_sva

// File: pse_limit_and_event_regs_bench.sv
/*
  Bench for the PSE register block: I2C register access, limit decode,
  power sequencing and event clearing. Assumes pse_i2c_host and the checker.
*/
module pse_limit_and_event_regs_bench import pse_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] DEV = {I2C_ADDR_HI, 4'h5};
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic mode_in = 1'b0;
  logic [3:0] sig_ok = 4'h0;
  logic [3:0] class_done = 4'h0;
  logic [3:0] removed = 4'h0;
  logic [11:0] class_code = 12'h000;
  logic [47:0] port_ma = 48'h0;
  logic scl, sda, sdo, irq_b;
  logic [3:0] power_on;
  logic [47:0] ceiling;
  logic [55:0] cutoff;
  logic [7:0] rd;
  logic [7:0] code [6] = '{8'h88, 8'h08, 8'h80, 8'hc0, 8'hda, 8'h40};
  logic [11:0] ma [6] = '{12'h06a, 12'h0d5, 12'h1a9, 12'h352, 12'h491, 12'h6a4};
  int error_cnt = 0;
  int checks = 0;
  int n;
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  pse_limit_and_event_regs #(.CUT_CYC(16)) dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .mode_in(mode_in), .addr_strap_in(4'h5), .supply_alarm_in(1'b1), .scl_in(scl),
    .sdi_in(sda), .sdo_out(sdo), .irq_b_out(irq_b), .sig_ok_in(sig_ok),
    .class_done_in(class_done), .class_code_in(class_code), .pd_removed_in(removed),
    .port_ma_in(port_ma), .power_on_out(power_on), .ceiling_ma_out(ceiling),
    .cutoff_q_out(cutoff));
  pse_i2c_host host_u (.clk_in(clk_in), .sdo_in(sdo), .scl_out(scl), .sda_out(sda));
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] p, exp);
    host_u.read_reg(DEV, p, rd);
    check($sformatf("reg %h", p), {8'h00, rd}, {8'h00, exp});
  endtask : rd_chk
  task automatic wr(input logic [7:0] p, d);
    host_u.write_reg(DEV, p, d);
    check("ack", 16'(host_u.acked), 16'h0001);
  endtask : wr
  // Mode pin is only sampled as reset ends, so change it under reset
  task automatic restart(input logic m);
    rst_b_in = 1'b0;
    mode_in = m;
    repeat (4) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_in);
  endtask : restart
  task automatic classify(input int p, input logic [2:0] c);
    sig_ok[p] = 1'b1;
    @(negedge clk_in);
    sig_ok[p] = 1'b0;
    class_done[p] = 1'b1;
    class_code[3*p +: 3] = c;
    @(negedge clk_in);
    class_done[p] = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask : classify
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Hang guard
  initial begin
    repeat (100000) @(negedge clk_in);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    restart(1'b0);
    for (int a = 0; a < 8; a++) begin
      rd_chk(a[7:0], (a < 2) ? RST_IRQ_CAUSE : RST_EVENTS);
    end
    check("irq", 16'(irq_b), 16'h0000);
    wr(ADDR_IRQ_MASK, 8'h00);
    rd_chk(ADDR_IRQ_MASK, 8'h00);
    rd_chk(ADDR_IRQ_MASK, 8'h00);
    check("irq", 16'(irq_b), 16'h0001);
    wr(ADDR_IRQ_CAUSE, 8'hff);
    wr(ADDR_POWER_EV_CLR, 8'hff);
    rd_chk(ADDR_IRQ_CAUSE, RST_IRQ_CAUSE);
    rd_chk(ADDR_POWER_EV_CLR, 8'h00);
    host_u.write_reg(DEV ^ 7'h01, ADDR_IRQ_MASK, 8'hff);
    check("ack", 16'(host_u.acked), 16'h0000);
    rd_chk(ADDR_IRQ_MASK, 8'h00);
    rd_chk(8'h40, 8'h00);
    // Slow controller for the ceiling decode table
    host_u.half = 9;
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CEIL_BASE, code[i]);
      check("ceiling", {4'h0, ceiling[11:0]}, {4'h0, ma[i]});
    end
    host_u.half = 4;
    wr(ADDR_CUT_BASE, 8'h7f);
    check("cutoff", {2'h0, cutoff[13:0]}, 16'h1275);
    wr(ADDR_CUT_BASE, 8'h3f);
    check("cutoff", {2'h0, cutoff[13:0]}, 16'h24ea);
    rd_chk(ADDR_CUT_BASE, 8'h3f);
    classify(0, CLASS_OVER);
    check("power", 16'(power_on[0]), 16'h0000);
    classify(0, 3'h3);
    check("power", 16'(power_on[0]), 16'h0001);
    rd_chk(ADDR_POWER_EV, 8'h11);
    rd_chk(ADDR_POWER_EV_CLR, 8'h11);
    rd_chk(ADDR_POWER_EV, 8'h00);
    // One step of cutoff, then a short and a sustained overload
    wr(ADDR_CUT_BASE, 8'h41);
    port_ma[11:0] = 12'h013;
    repeat (8) @(negedge clk_in);
    port_ma[11:0] = 12'h000;
    // One quiet cycle so the timer really restarts
    @(negedge clk_in);
    check("power", 16'(power_on[0]), 16'h0001);
    port_ma[11:0] = 12'h013;
    for (n = 0; n < 40 && power_on[0]; n++) @(negedge clk_in);
    port_ma[11:0] = 12'h000;
    check("trip time", 16'(n), 16'h0010);
    check("power", 16'(power_on[0]), 16'h0000);
    if (power_on[0]) tally_and_finish();
    rd_chk(ADDR_FAULT_EV, 8'h01);
    classify(0, 3'h3);
    removed[0] = 1'b1;
    @(negedge clk_in);
    removed[0] = 1'b0;
    repeat (2) @(negedge clk_in);
    check("power", 16'(power_on[0]), 16'h0000);
    rd_chk(ADDR_FAULT_EV_CLR, 8'h11);
    rd_chk(ADDR_FAULT_EV, 8'h00);
    // Host loads the class 3 default cutoff itself
    wr(ADDR_CUT_BASE, CUT_CLASS3);
    check("cutoff", {2'h0, cutoff[13:0]}, 16'h05dc);
    restart(1'b1);
    classify(0, CLASS_4);
    classify(1, CLASS_1);
    check("ceiling", {4'h0, ceiling[11:0]}, 16'h0352);
    check("cutoff", {2'h0, cutoff[13:0]}, 16'h09f6);
    check("ceiling", {4'h0, ceiling[23:12]}, 16'h01a9);
    check("cutoff", {2'h0, cutoff[27:14]}, 16'h01c2);
    tally_and_finish();
  end
endmodule : pse_limit_and_event_regs_bench
bind pse_limit_and_event_regs pse_limit_and_event_regs_sva #(.PORTS(PORTS), .CUT_CYC(CUT_CYC))
  chk_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .mode_in(mode_in), .scl_in(scl_in),
  .sdi_in(sdi_in), .sdo_out(sdo_out), .irq_b_out(irq_b_out), .class_done_in(class_done_in),
  .class_code_in(class_code_in), .pd_removed_in(pd_removed_in), .port_ma_in(port_ma_in),
  .power_on_out(power_on_out), .ceiling_ma_out(ceiling_ma_out), .cutoff_q_out(cutoff_q_out));
